// ### btk_timer.sv
// Bit timer keying unit with edge capture FIFO.
`timescale 1ns/10ps
`default_nettype none

module btk_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      used_reg;
	wire              doPush = inValid && inReady;
	wire              doPop  = outValid && outReady;
	assign inReady  = (used_reg != (AW+1)'(DEPTH));
	assign outValid = (used_reg != '0);
	assign outData  = mem[rdPtr_reg];
	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			used_reg  <= '0;
		end else begin
			if (doPush) wrPtr_reg <= wrPtr_reg + AW'(1);
			if (doPop) rdPtr_reg <= rdPtr_reg + AW'(1);
			used_reg <= used_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end
endmodule // btk_fifo

module btk_timer (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] clock_divide_select,
	input  wire logic [7:0] ioAddr,
	input  wire logic       ioWrite,
	input  wire logic       ioRead,
	input  wire logic [7:0] ioWdata,
	output logic      [7:0] ioRdata,
	input  wire logic       edge_input_pin,
	output logic            txKey,
	output logic            irqDone,
	output logic            buffer_interrupt,
	output logic      [7:0] irqVector
);
	import btk_pkg::*;

	function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	logic [7:0] countLow_reg;
	logic [1:0] countHi_reg;
	logic [1:0] mode_reg;
	logic       ie_reg;
	logic       done_reg;
	logic       dataBit_reg;
	logic       bufFlag_reg;
	logic       bufFull_reg;
	logic       shiftBit_reg;
	logic       active_reg;
	logic [9:0] downCnt_reg;
	logic [9:0] upCnt_reg;
	logic [6:0] div_reg;
	logic       sync1_reg;
	logic       sync2_reg;
	logic       pinLast_reg;
	logic       capVal_reg;
	logic       ovfPend_reg;
	logic [7:0] ioRdata_reg;
	logic       txKey_reg;
	logic       irqDone_reg;
	logic       irqBuf_reg;
	logic [7:0] irqVec_reg;

	wire wrLow  = ioWrite && hitAddr(ioAddr, ADDR_COUNT_LOW);
	wire wrCtl  = ioWrite && hitAddr(ioAddr, ADDR_CONTROL);
	wire rdLow  = ioRead && hitAddr(ioAddr, ADDR_COUNT_LOW);
	wire rdCtl  = ioRead && hitAddr(ioAddr, ADDR_CONTROL);
	wire [9:0] countVal = {countHi_reg, countLow_reg};
	wire isTx   = mode_reg[0];
	wire isRx   = (mode_reg == MODE_RX);

	// Tick at the divided system clock rate.
	wire [6:0] divMask = (clock_divide_select == 2'h3) ? 7'h0F :
		(clock_divide_select == 2'h2) ? 7'h1F :
		(clock_divide_select == 2'h1) ? 7'h3F : 7'h7F;
	wire tick = ((div_reg & divMask) == divMask);

	// Transmit: load the buffered bit when idle, or when the interval ends.
	wire expire  = active_reg && tick && (downCnt_reg == 10'h000);
	wire needBit = isTx && tick && (!active_reg || (downCnt_reg == 10'h000));
	wire takeBit = needBit && bufFull_reg;
	wire txDone  = isTx && expire && !bufFull_reg;

	// Receive: detect edges on the synchronised pin.
	wire pinEdge = isRx && (sync2_reg != pinLast_reg);
	wire rxOvf   = isRx && tick && !pinEdge && (upCnt_reg == COUNT_MAX);

	// Captured edges queue in the FIFO so software reads them in order.
	logic       qInReady;
	logic       qOutValid;
	logic [10:0] qOutData;
	wire qPop = qOutValid && !capVal_reg;
	btk_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) uQueue (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.inValid (pinEdge),
		.inReady (qInReady),
		.inData  ({sync2_reg, upCnt_reg}),
		.outValid(qOutValid),
		.outReady(qPop),
		.outData (qOutData)
	);

	wire doneSet = txDone || (qPop && isRx);
	wire bufSet  = takeBit || rxOvf || ovfPend_reg || (pinEdge && !qInReady);
	wire [7:0] ctlView = {countHi_reg, mode_reg, ie_reg, done_reg, dataBit_reg, bufFlag_reg};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg   <= '0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			pinLast_reg <= 1'b0;
		end else begin
			div_reg   <= div_reg + 7'h01;
			sync1_reg <= edge_input_pin;
			sync2_reg <= sync1_reg;
			pinLast_reg <= sync2_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			countLow_reg <= RESET_BYTE;
			countHi_reg  <= 2'h0;
			mode_reg     <= MODE_OFF;
			ie_reg       <= 1'b0;
			dataBit_reg  <= 1'b0;
			bufFull_reg  <= 1'b0;
			capVal_reg   <= 1'b0;
		end else begin
			capVal_reg <= qPop || (capVal_reg && !rdCtl);
			if (qPop && isRx) begin
				{dataBit_reg, countHi_reg, countLow_reg} <= qOutData;
			end else begin
				if (wrLow) countLow_reg <= ioWdata;
				if (wrCtl) begin
					countHi_reg <= ioWdata[CNT_HI_POS +: 2];
					dataBit_reg <= ioWdata[DATA_POS];
				end
			end
			if (wrCtl) begin
				mode_reg <= ioWdata[MODE_POS +: 2];
				ie_reg   <= ioWdata[IE_POS];
			end
			if (wrCtl && ioWdata[MODE_POS]) bufFull_reg <= 1'b1;
			else if (takeBit || !isTx) bufFull_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			active_reg   <= 1'b0;
			shiftBit_reg <= 1'b0;
			downCnt_reg  <= '0;
			upCnt_reg    <= '0;
			ovfPend_reg  <= 1'b0;
		end else begin
			ovfPend_reg <= 1'b0;
			if (!isTx) begin
				active_reg <= 1'b0;
			end else if (takeBit) begin
				active_reg   <= 1'b1;
				shiftBit_reg <= dataBit_reg;
				downCnt_reg  <= countVal;
			end else if (expire) begin
				active_reg <= 1'b0;
			end else if (active_reg && tick) begin
				downCnt_reg <= downCnt_reg - 10'h001;
			end
			if (!isRx || pinEdge) begin
				upCnt_reg <= (pinEdge && tick) ? 10'h001 : 10'h000;
			end else if (tick) begin
				upCnt_reg <= upCnt_reg + 10'h001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_reg    <= 1'b0;
			bufFlag_reg <= 1'b0;
		end else begin
			done_reg    <= doneSet || (done_reg && !rdCtl);
			bufFlag_reg <= bufSet || (bufFlag_reg && !rdCtl);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioRdata_reg <= RESET_BYTE;
			txKey_reg   <= 1'b0;
			irqDone_reg <= 1'b0;
			irqBuf_reg  <= 1'b0;
			irqVec_reg  <= RESET_BYTE;
		end else begin
			ioRdata_reg <= rdCtl ? ctlView : (rdLow ? countLow_reg : RESET_BYTE);
			txKey_reg   <= (mode_reg == MODE_TX_KEYED) && active_reg && shiftBit_reg;
			irqDone_reg <= ie_reg && done_reg;
			irqBuf_reg  <= ie_reg && bufFlag_reg;
			irqVec_reg  <= (ie_reg && bufFlag_reg) ? VEC_BUFFER :
				((ie_reg && done_reg) ? VEC_DONE : RESET_BYTE);
		end
	end

	assign ioRdata          = ioRdata_reg;
	assign txKey            = txKey_reg;
	assign irqDone          = irqDone_reg;
	assign buffer_interrupt = irqBuf_reg;
	assign irqVector        = irqVec_reg;
endmodule // btk_timer

`default_nettype wire

// ### btk_pkg.sv
// Package of constants for the bit timer keying unit.
// Function
// - Count value is count low plus control[7:6].
// - Transmit interval lasts count value plus one.
// - Tick is crystal divided by 16..128.
// - Mode field selects off, transmit, receive.
// - Interrupt enable gates both flag interrupts.
// - Buffer flag vectors 0x04, done flag 0x02.
// - Transmit done when buffer empty and zero.
// - Receive edge on pin sets done flag; an edge arriving with the FIFO full sets buffer flag instead.
// - Control read clears both read-only flags.
// - Taking buffered bit sets buffer flag.
// - Receive writes edge polarity into data bit.
// - Receive count holds ticks since edge.
// - Receive counter overflow sets buffer flag.
package btk_pkg;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h20;
	localparam logic [7:0] ADDR_CONTROL   = 8'h21;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam int         CNT_HI_POS     = 6;
	localparam int         MODE_POS       = 4;
	localparam int         IE_POS         = 3;
	localparam int         DONE_POS       = 2;
	localparam int         DATA_POS       = 1;
	localparam int         BUF_POS        = 0;
	localparam logic [1:0] MODE_OFF       = 2'h0;
	localparam logic [1:0] MODE_TX_QUIET  = 2'h1;
	localparam logic [1:0] MODE_RX        = 2'h2;
	localparam logic [1:0] MODE_TX_KEYED  = 2'h3;
	localparam logic [7:0] VEC_BUFFER     = 8'h04;
	localparam logic [7:0] VEC_DONE       = 8'h02;
	localparam logic [9:0] COUNT_MAX      = 10'h3FF;
	localparam int         FIFO_DEPTH     = 8;
	localparam int         FIFO_WIDTH     = 11;
endpackage

// ### btk_timer_chk.sv
// Port-level assertions for the bit timer keying unit.
`timescale 1ns/10ps
`default_nettype none
module btk_timer_chk (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic [1:0] clock_divide_select,
	input wire logic [7:0] ioAddr,
	input wire logic       ioWrite,
	input wire logic       ioRead,
	input wire logic [7:0] ioWdata,
	input wire logic [7:0] ioRdata,
	input wire logic       edge_input_pin,
	input wire logic       txKey,
	input wire logic       irqDone,
	input wire logic       buffer_interrupt,
	input wire logic [7:0] irqVector
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire ctlRd = ioRead && ioAddr == 8'h21;
	wire ctlWr = ioWrite && ioAddr == 8'h21;
	chk_rdata_idle: assert property (!ioRead |=> ioRdata == 8'h00)
		else $error("read data not idle");
	chk_unmapped_zero: assert property (ioRead && ioAddr[7:1] != 7'h10 |=> ioRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_vec_buffer: assert property (buffer_interrupt |-> irqVector == 8'h04)
		else $error("buffer vector wrong");
	chk_vec_done: assert property (irqDone && !buffer_interrupt |-> irqVector == 8'h02)
		else $error("done vector wrong");
	chk_vec_none: assert property (!irqDone && !buffer_interrupt |-> irqVector == 8'h00)
		else $error("vector without interrupt");
	chk_done_seen: assert property (ctlRd && irqDone |=> ioRdata[3:2] == 2'b11)
		else $error("done interrupt without flag");
	chk_buf_seen: assert property (ctlRd && buffer_interrupt |=> ioRdata[3] && ioRdata[0])
		else $error("buffer interrupt without flag");
	chk_irq_off: assert property (ctlWr && !ioWdata[3] |-> ##2 !irqDone && !buffer_interrupt)
		else $error("interrupt while disabled");
	chk_key_quiet: assert property (ctlWr && ioWdata[5:4] != 2'b11 |-> ##2 !txKey [*3])
		else $error("key active outside keyed mode");
	chk_key_hold: assert property ($rose(txKey) |-> txKey [*8])
		else $error("key interval too short");
	cover property (irqDone);
	cover property (buffer_interrupt);
	cover property ($fell(txKey));
endmodule // btk_timer_chk
bind btk_timer btk_timer_chk u_chk (.sys_clk, .arst_n, .clock_divide_select, .ioAddr, .ioWrite,
	.ioRead, .ioWdata, .ioRdata, .edge_input_pin, .txKey, .irqDone, .buffer_interrupt, .irqVector);
`default_nettype wire

// ### btk_partner.sv
// Far-side model: drives the edge pin and times key-on intervals.
`timescale 1ns/10ps
`default_nettype none
module btk_partner (
	input wire logic       sys_clk,
	input wire logic       txKey,
	input wire logic       pinCmd,
	output logic           edge_input_pin,
	output logic     [7:0] keyLen
);
	logic [7:0] run = 8'h00;
	initial keyLen = 8'h00;
	always @(posedge sys_clk) begin
		edge_input_pin <= pinCmd;
		run <= txKey ? run + 8'h01 : 8'h00;
		if (!txKey && run != 8'h00) begin
			keyLen <= run;
		end
	end
endmodule // btk_partner
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the bit timer keying unit.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import btk_pkg::*;
	logic sys_clk = 0, arst_n = 0, ioWrite = 0, ioRead = 0, pinCmd = 0;
	logic [1:0] clock_divide_select = 2'h3;
	logic [7:0] ioAddr = 8'h00, ioWdata = 8'h00, ioRdata, irqVector, rd, keyLen, lfsr = 8'h49;
	logic edge_input_pin, txKey, irqDone, buffer_interrupt;
	int fails = 0, samples_checked = 0;
	btk_timer DUT (.sys_clk, .arst_n, .clock_divide_select, .ioAddr, .ioWrite, .ioRead,
		.ioWdata, .ioRdata, .edge_input_pin, .txKey, .irqDone, .buffer_interrupt, .irqVector);
	btk_partner u_far (.sys_clk, .txKey, .pinCmd, .edge_input_pin, .keyLen);
	initial forever #50 sys_clk = ~sys_clk;
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task test_done;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task io(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{ioWrite, ioRead, ioAddr, ioWdata} = {w, !w, a, d};
		@(negedge sys_clk);
		{ioWrite, ioRead} = 2'b00;
		rd = ioRdata;
	endtask
	task waitirq(input logic b);
		int i;
		i = 0;
		while (i < 20000 && (b ? buffer_interrupt : irqDone) !== 1'b1) begin
			@(negedge sys_clk);
			i++;
		end
		if ((b ? buffer_interrupt : irqDone) !== 1'b1) begin
			fails++;
			test_done;
		end
	endtask
	initial begin
		repeat (12) @(negedge sys_clk);
		arst_n = 1;
		io(0, ADDR_COUNT_LOW, 8'h00); chk(rd, RESET_BYTE);
		io(0, ADDR_CONTROL, 8'h00); chk(rd, RESET_BYTE);
		io(0, 8'h22, 8'h00); chk(rd, 8'h00);
		for (int k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			io(1, ADDR_COUNT_LOW, lfsr);
			io(0, ADDR_COUNT_LOW, 8'h00); chk(rd, lfsr);
		end
		io(1, ADDR_COUNT_LOW, 8'h02);
		io(1, ADDR_CONTROL, 8'h3A);
		waitirq(1);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'hFD, 8'h39);
		waitirq(0);
		repeat (4) @(negedge sys_clk);
		chk(keyLen, 8'h30);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'hFD, 8'h3C);
		io(1, ADDR_CONTROL, 8'h08);
		io(0, ADDR_CONTROL, 8'h00); chk(rd, 8'h08);
		clock_divide_select = 2'h2;
		io(1, ADDR_COUNT_LOW, 8'h00);
		io(1, ADDR_CONTROL, 8'h3A);
		waitirq(1);
		waitirq(0);
		repeat (4) @(negedge sys_clk);
		chk(keyLen, 8'h20);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'h05, 8'h05);
		clock_divide_select = 2'h3;
		io(1, ADDR_CONTROL, 8'h1A);
		waitirq(1); chk({7'h00, txKey}, 8'h00);
		waitirq(0);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'h05, 8'h05);
		io(1, ADDR_CONTROL, 8'h28);
		pinCmd = 1;
		waitirq(0);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'h06, 8'h06);
		repeat (80) @(negedge sys_clk);
		pinCmd = 0;
		waitirq(0);
		io(0, ADDR_COUNT_LOW, 8'h00); chk({7'h00, rd >= 8'h04 && rd <= 8'h07}, 8'h01);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'h06, 8'h04);
		waitirq(1); chk(irqVector, VEC_BUFFER);
		io(0, ADDR_CONTROL, 8'h00); chk(rd & 8'h01, 8'h01);
		io(1, ADDR_CONTROL, 8'h00);
		repeat (4) @(negedge sys_clk);
		test_done;
	end
endmodule // tb
`default_nettype wire
